// ==== shared/vecsel_pkg.sv ====
// Purpose: constants shared by the interrupt vector selector
// Assumes: byte addresses on a 32-bit AXI4-Lite bus, 16-bit registers in the low half
// Notes:   one place for every offset, field and vector constant
package vecsel_pkg;

	// ----------------------------------------------------------------
	// register map (byte addresses)
	// ----------------------------------------------------------------
	localparam int         ADDR_W       = 8;
	localparam logic [7:0] CTRL_OFS     = 8'h00;
	localparam logic [7:0] TRAP_OFS     = 8'h04;
	localparam logic [7:0] STAT_OFS     = 8'h08;
	localparam logic [7:0] EVT_STAT_OFS = 8'h0c;
	localparam logic [7:0] EVT_CLR_OFS  = 8'h10;
	localparam logic [7:0] EVT_EN_OFS   = 8'h14;
	localparam logic [7:0] FLAG_BASE    = 8'h20;
	localparam logic [7:0] ENAB_BASE    = 8'h40;
	localparam logic [7:0] PRIO_BASE    = 8'h60;

	// ----------------------------------------------------------------
	// fields
	// ----------------------------------------------------------------
	localparam int ALT_SEL_BIT    = 15;
	localparam int TRAP_LSB       = 1;
	localparam int TRAP_N         = 4;
	localparam int STAT_VEC_LSB   = 0;
	localparam int STAT_TRAP_BIT  = 7;
	localparam int STAT_LVL_LSB   = 8;
	localparam int EV_TAKEN       = 0;
	localparam int EV_TRAP        = 1;
	localparam int EV_W           = 2;
	localparam logic [15:0] PRIO_MASK = 16'h7777;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ----------------------------------------------------------------
	// vectors
	// ----------------------------------------------------------------
	localparam int NUM_VEC       = 80;
	localparam int WORD_W        = 16;
	localparam int NUM_WORDS     = 5;
	localparam int PRIO_W        = 3;
	localparam int PRIO_STRIDE   = 4;
	localparam int PRIO_PER_REG  = 4;
	localparam int NUM_PRIO_REGS = 20;
	localparam int VEC_W         = 7;
	localparam int LVL_W         = 4;
	localparam int VEC_SHIFT     = 1;
	localparam logic [23:0] RESET_ADDR     = 24'h000000;
	localparam logic [23:0] TRAP_BASE_ADDR = 24'h000004;
	localparam logic [23:0] USER_BASE_ADDR = 24'h000014;
	localparam logic [23:0] ALT_OFFSET     = 24'h000100;
	localparam logic [3:0]  TRAP_TOP_LEVEL = 4'hf;
	// vectors that own a request source; 62 is the clock alarm, 77 the highest
	localparam logic [NUM_VEC-1:0] IMPL_MASK = 80'h210e_4006_22e3_fe1f_3fef;

endpackage : vecsel_pkg

// ==== core/request_flag_bank.sv ====
// Purpose: one word of sticky request flags
// Assumes: set and write arrive on the same clock
// Notes:   hardware set beats a software clear in the same cycle
`timescale 1ns/1ps
module request_flag_bank #(
	parameter int             W    = 16,
	parameter logic [W-1:0]   IMPL = '1
) (
	input  wire logic         clk_i,
	input  wire logic         rst_n_i,
	input  wire logic [W-1:0] set_i,
	input  wire logic         wr_i,
	input  wire logic [W-1:0] wdata_i,
	output logic      [W-1:0] flags_o
);

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			flags_o <= '0;
		else
			flags_o <= ((wr_i ? wdata_i : flags_o) | set_i) & IMPL;
	end

	set_wins_a : assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(set_i & IMPL) != '0 |=> (flags_o & $past(set_i & IMPL)) == $past(set_i & IMPL))
		else $error("request flag lost its set");

endmodule : request_flag_bank

// ==== core/priority_picker.sv ====
// Purpose: pick the winning pending source
// Assumes: levels are compared against the cpu level, zero never wins
// Notes:   purely combinational; clock only feeds the checks
`timescale 1ns/1ps
module priority_picker #(
	parameter int N  = 80,
	parameter int LW = 3,
	parameter int IW = 7
) (
	input  wire logic            clk_i,
	input  wire logic            rst_n_i,
	input  wire logic [N-1:0]    pend_i,
	input  wire logic [N*LW-1:0] level_flat_i,
	input  wire logic [LW:0]     thresh_i,
	output logic                 found_o,
	output logic      [IW-1:0]   vec_o,
	output logic      [LW-1:0]   level_o
);

	logic lower_tie;

	// strict compare keeps the lowest vector among equal levels
	always_comb
	begin
		found_o = 1'b0;
		vec_o   = '0;
		level_o = '0;
		for (int i = 0; i < N; i++)
		begin
			if (pend_i[i] && {1'b0, level_flat_i[i*LW +: LW]} > thresh_i
			    && (!found_o || level_flat_i[i*LW +: LW] > level_o))
			begin
				found_o = 1'b1;
				vec_o   = IW'(i);
				level_o = level_flat_i[i*LW +: LW];
			end
		end
	end

	always_comb
	begin
		lower_tie = 1'b0;
		for (int i = 0; i < N; i++)
			if (found_o && i < int'(vec_o) && pend_i[i] && level_flat_i[i*LW +: LW] == level_o)
				lower_tie = 1'b1;
	end

	tie_low_a : assert property (@(posedge clk_i) disable iff (!rst_n_i)
		found_o |-> !lower_tie)
		else $error("lower vector of equal level lost");

	pick_valid_a : assert property (@(posedge clk_i) disable iff (!rst_n_i)
		found_o |-> pend_i[vec_o] && {1'b0, level_o} > thresh_i)
		else $error("winner not pending or below level");

endmodule : priority_picker

// ==== core/interrupt_vector_selector.sv ====
// Purpose: vector selection and request flags of the interrupt controller
// Assumes: request sources and cpu signals run on MCLK_I; bus is AXI4-Lite
// Notes:   one offer to the cpu at a time, held until acknowledged
// Contract
// - alternate select set makes every trap and interrupt vector come from the alternate table
// - alternate table has the same slot layout as the primary table
// - alternate table follows the primary one; trap 0 at 000004h or 000104h
// - reset fetches no vector and is no exception
// - reset clears registers, forces the program counter to zero, start at 000000h
// - eight trap vectors from 000004h, two apart; traps 1 to 4 are real
// - user vector 0 is external interrupt 0 at 000014h or 000114h
// - flag and enable of vector n live in word n/16, bit n mod 16
// - three-bit priority of n in register n/4 at bit 4 times n mod 4
// - highest user vector is 77; unlisted vectors have no source
// - clock alarm is vector 62, flag word 3 bit 14, priority 15 bits 10:8
// - flags set by sources stay until software clears; enables gate them
// - taken request latches vector number and new level into the status latch
// - equal priority favours the lower vector
`timescale 1ns/1ps
module interrupt_vector_selector
	import vecsel_pkg::*;
(
	input  wire logic                           MCLK_I,
	input  wire logic                           ARST_N_I,
	input  wire logic [vecsel_pkg::ADDR_W-1:0]  S_AXI_AWADDR_I,
	input  wire logic                           S_AXI_AWVALID_I,
	output logic                                S_AXI_AWREADY_O,
	input  wire logic [31:0]                    S_AXI_WDATA_I,
	input  wire logic [3:0]                     S_AXI_WSTRB_I,
	input  wire logic                           S_AXI_WVALID_I,
	output logic                                S_AXI_WREADY_O,
	output logic      [1:0]                     S_AXI_BRESP_O,
	output logic                                S_AXI_BVALID_O,
	input  wire logic                           S_AXI_BREADY_I,
	input  wire logic [vecsel_pkg::ADDR_W-1:0]  S_AXI_ARADDR_I,
	input  wire logic                           S_AXI_ARVALID_I,
	output logic                                S_AXI_ARREADY_O,
	output logic      [31:0]                    S_AXI_RDATA_O,
	output logic      [1:0]                     S_AXI_RRESP_O,
	output logic                                S_AXI_RVALID_O,
	input  wire logic                           S_AXI_RREADY_I,
	input  wire logic [vecsel_pkg::NUM_VEC-1:0] SRC_REQ_I,
	input  wire logic [vecsel_pkg::TRAP_N-1:0]  TRAP_I,
	input  wire logic [vecsel_pkg::LVL_W-1:0]   CPU_IPL_I,
	input  wire logic                           CPU_ACK_I,
	output logic                                CPU_REQ_O,
	output logic                                CPU_TRAP_O,
	output logic      [vecsel_pkg::VEC_W-1:0]   CPU_VEC_NUM_O,
	output logic      [vecsel_pkg::LVL_W-1:0]   CPU_LEVEL_O,
	output logic      [23:0]                    CPU_VEC_ADDR_O,
	output logic                                CPU_PC_FORCE_O,
	output logic                                IRQ_O
);
	import vecsel_pkg::*;

	typedef enum logic {ST_IDLE, ST_OFFER} state_e;

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	logic                     aw_held, w_held, do_write;
	logic                     next_aw_held, next_w_held;
	logic [ADDR_W-1:0]        aw_addr;
	logic [31:0]              w_data;
	logic [3:0]               w_strb;
	logic [15:0]              wmask;
	logic                     wr_ctrl, wr_trap, wr_evclr, wr_even, wr_hit;
	logic [NUM_WORDS-1:0]     wr_flag, wr_enab;
	logic [NUM_PRIO_REGS-1:0] wr_prio;
	logic [31:0]              rd_data;
	logic                     rd_hit;
	logic                     alt_sel;
	logic [TRAP_N-1:0]        trap_flags;
	logic [NUM_VEC-1:0]       flags, enables, pend;
	logic [WORD_W-1:0]        enab_reg [NUM_WORDS];
	logic [15:0]              prio_reg [NUM_PRIO_REGS];
	logic [NUM_VEC*PRIO_W-1:0] prio_flat;
	logic                     user_found, trap_found;
	logic [VEC_W-1:0]         user_vec, trap_num;
	logic [PRIO_W-1:0]        user_lvl, pick_prio;
	logic [LVL_W-1:0]         trap_lvl;
	logic [VEC_W-1:0]         status_vec;
	logic                     status_trap;
	logic [LVL_W-1:0]         status_lvl;
	logic [EV_W-1:0]          ev_status, ev_en, ev_set;
	state_e                   state;
	logic [15:0]              m_ctrl, m_trap, m_evclr, m_even;
	logic [WORD_W-1:0]        flag_wdata [NUM_WORDS];

	function automatic logic [15:0] merge16(input logic [15:0] old);
		merge16 = (old & ~wmask) | (w_data[15:0] & wmask);
	endfunction : merge16

	function automatic logic [23:0] vec_addr(input logic trap, input logic [VEC_W-1:0] num,
	                                         input logic alt);
		logic [23:0] a;
		a = (trap ? TRAP_BASE_ADDR : USER_BASE_ADDR) + (24'(num) << VEC_SHIFT);
		vec_addr = alt ? a + ALT_OFFSET : a;
	endfunction : vec_addr

	// merged words sit in always_comb so a new strobe or data word is seen
	always_comb
	begin
		m_ctrl  = merge16({alt_sel, 15'h0000});
		m_trap  = merge16(16'(trap_flags) << TRAP_LSB);
		m_evclr = merge16(16'h0000);
		m_even  = merge16(16'(ev_en));
		for (int k = 0; k < NUM_WORDS; k++)
			flag_wdata[k] = merge16(flags[k*WORD_W +: WORD_W]);
	end

	// ----------------------------------------------------------------
	// axi4-lite write channels
	// ----------------------------------------------------------------
	assign do_write     = aw_held & w_held & ~S_AXI_BVALID_O;
	assign next_aw_held = (aw_held | (S_AXI_AWVALID_I & S_AXI_AWREADY_O)) & ~do_write;
	assign next_w_held  = (w_held | (S_AXI_WVALID_I & S_AXI_WREADY_O)) & ~do_write;
	assign wmask        = {{8{w_strb[1]}}, {8{w_strb[0]}}};

	always_ff @(posedge MCLK_I or negedge ARST_N_I)
	begin
		if (!ARST_N_I)
		begin
			aw_held         <= 1'b0;
			aw_addr         <= '0;
			S_AXI_AWREADY_O <= 1'b1;
		end
		else
		begin
			aw_held         <= next_aw_held;
			S_AXI_AWREADY_O <= ~next_aw_held;
			if (S_AXI_AWVALID_I && S_AXI_AWREADY_O)
				aw_addr <= S_AXI_AWADDR_I;
		end
	end

	always_ff @(posedge MCLK_I or negedge ARST_N_I)
	begin
		if (!ARST_N_I)
		begin
			w_held         <= 1'b0;
			w_data         <= '0;
			w_strb         <= '0;
			S_AXI_WREADY_O <= 1'b1;
		end
		else
		begin
			w_held         <= next_w_held;
			S_AXI_WREADY_O <= ~next_w_held;
			if (S_AXI_WVALID_I && S_AXI_WREADY_O)
			begin
				w_data <= S_AXI_WDATA_I;
				w_strb <= S_AXI_WSTRB_I;
			end
		end
	end

	always_comb
	begin
		wr_ctrl  = 1'b0;
		wr_trap  = 1'b0;
		wr_evclr = 1'b0;
		wr_even  = 1'b0;
		wr_flag  = '0;
		wr_enab  = '0;
		wr_prio  = '0;
		wr_hit   = (aw_addr == STAT_OFS) || (aw_addr == EVT_STAT_OFS);
		wr_ctrl  = do_write && aw_addr == CTRL_OFS;
		wr_trap  = do_write && aw_addr == TRAP_OFS;
		wr_evclr = do_write && aw_addr == EVT_CLR_OFS;
		wr_even  = do_write && aw_addr == EVT_EN_OFS;
		wr_hit   = wr_hit || aw_addr == CTRL_OFS || aw_addr == TRAP_OFS
		           || aw_addr == EVT_CLR_OFS || aw_addr == EVT_EN_OFS;
		for (int k = 0; k < NUM_WORDS; k++)
		begin
			wr_flag[k] = do_write && aw_addr == FLAG_BASE + 8'(k << 2);
			wr_enab[k] = do_write && aw_addr == ENAB_BASE + 8'(k << 2);
			wr_hit     = wr_hit || aw_addr == FLAG_BASE + 8'(k << 2) || aw_addr == ENAB_BASE + 8'(k << 2);
		end
		for (int k = 0; k < NUM_PRIO_REGS; k++)
		begin
			wr_prio[k] = do_write && aw_addr == PRIO_BASE + 8'(k << 2);
			wr_hit     = wr_hit || aw_addr == PRIO_BASE + 8'(k << 2);
		end
	end

	always_ff @(posedge MCLK_I or negedge ARST_N_I)
	begin
		if (!ARST_N_I)
		begin
			S_AXI_BVALID_O <= 1'b0;
			S_AXI_BRESP_O  <= RESP_OKAY;
		end
		else if (do_write)
		begin
			S_AXI_BVALID_O <= 1'b1;
			S_AXI_BRESP_O  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
		end
		else if (S_AXI_BREADY_I)
			S_AXI_BVALID_O <= 1'b0;
	end

	// ----------------------------------------------------------------
	// axi4-lite read channels
	// ----------------------------------------------------------------
	always_comb
	begin
		rd_data = '0;
		rd_hit  = 1'b1;
		case (S_AXI_ARADDR_I)
			CTRL_OFS     : rd_data[ALT_SEL_BIT] = alt_sel;
			TRAP_OFS     : rd_data[TRAP_LSB +: TRAP_N] = trap_flags;
			STAT_OFS     :
			begin
				rd_data[STAT_VEC_LSB +: VEC_W] = status_vec;
				rd_data[STAT_TRAP_BIT]         = status_trap;
				rd_data[STAT_LVL_LSB +: LVL_W] = status_lvl;
			end
			EVT_STAT_OFS : rd_data[EV_W-1:0] = ev_status;
			EVT_EN_OFS   : rd_data[EV_W-1:0] = ev_en;
			EVT_CLR_OFS  : rd_data = '0;
			default      : rd_hit = 1'b0;
		endcase
		for (int k = 0; k < NUM_WORDS; k++)
		begin
			if (S_AXI_ARADDR_I == FLAG_BASE + 8'(k << 2))
			begin
				rd_data[15:0] = flags[k*WORD_W +: WORD_W];
				rd_hit        = 1'b1;
			end
			if (S_AXI_ARADDR_I == ENAB_BASE + 8'(k << 2))
			begin
				rd_data[15:0] = enab_reg[k];
				rd_hit        = 1'b1;
			end
		end
		for (int k = 0; k < NUM_PRIO_REGS; k++)
			if (S_AXI_ARADDR_I == PRIO_BASE + 8'(k << 2))
			begin
				rd_data[15:0] = prio_reg[k];
				rd_hit        = 1'b1;
			end
	end

	always_ff @(posedge MCLK_I or negedge ARST_N_I)
	begin
		if (!ARST_N_I)
		begin
			S_AXI_ARREADY_O <= 1'b1;
			S_AXI_RVALID_O  <= 1'b0;
			S_AXI_RDATA_O   <= '0;
			S_AXI_RRESP_O   <= RESP_OKAY;
		end
		else if (S_AXI_ARVALID_I && S_AXI_ARREADY_O)
		begin
			S_AXI_ARREADY_O <= 1'b0;
			S_AXI_RVALID_O  <= 1'b1;
			S_AXI_RDATA_O   <= rd_data;
			S_AXI_RRESP_O   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
		end
		else if (S_AXI_RVALID_O && S_AXI_RREADY_I)
		begin
			S_AXI_ARREADY_O <= 1'b1;
			S_AXI_RVALID_O  <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// control, trap, enable and priority registers
	// ----------------------------------------------------------------
	always_ff @(posedge MCLK_I or negedge ARST_N_I)
	begin
		if (!ARST_N_I)
		begin
			alt_sel    <= 1'b0;
			trap_flags <= '0;
		end
		else
		begin
			if (wr_ctrl)
				alt_sel <= m_ctrl[ALT_SEL_BIT];
			trap_flags <= (wr_trap ? m_trap[TRAP_LSB +: TRAP_N] : trap_flags) | TRAP_I;
		end
	end

	always_ff @(posedge MCLK_I or negedge ARST_N_I)
	begin
		if (!ARST_N_I)
		begin
			for (int k = 0; k < NUM_WORDS; k++)
				enab_reg[k] <= '0;
			for (int k = 0; k < NUM_PRIO_REGS; k++)
				prio_reg[k] <= '0;
		end
		else
		begin
			for (int k = 0; k < NUM_WORDS; k++)
				if (wr_enab[k])
					enab_reg[k] <= merge16(enab_reg[k]) & IMPL_MASK[k*WORD_W +: WORD_W];
			for (int k = 0; k < NUM_PRIO_REGS; k++)
				if (wr_prio[k])
					prio_reg[k] <= merge16(prio_reg[k]) & PRIO_MASK;
		end
	end

	// ----------------------------------------------------------------
	// flags, priorities, arbitration
	// ----------------------------------------------------------------
	for (genvar g = 0; g < NUM_WORDS; g++)
	begin : g_word
		request_flag_bank #(
			.W    (WORD_W),
			.IMPL (IMPL_MASK[g*WORD_W +: WORD_W])
		) u_bank (
			.clk_i   (MCLK_I),
			.rst_n_i (ARST_N_I),
			.set_i   (SRC_REQ_I[g*WORD_W +: WORD_W]),
			.wr_i    (wr_flag[g]),
			.wdata_i (flag_wdata[g]),
			.flags_o (flags[g*WORD_W +: WORD_W])
		);
		assign enables[g*WORD_W +: WORD_W] = enab_reg[g];
	end

	for (genvar n = 0; n < NUM_VEC; n++)
	begin : g_prio
		assign prio_flat[n*PRIO_W +: PRIO_W] =
			prio_reg[n / PRIO_PER_REG][(n % PRIO_PER_REG) * PRIO_STRIDE +: PRIO_W];
	end

	assign pend      = flags & enables & IMPL_MASK;
	assign pick_prio = prio_flat[int'(user_vec) * PRIO_W +: PRIO_W];

	priority_picker #(
		.N  (NUM_VEC),
		.LW (PRIO_W),
		.IW (VEC_W)
	) u_pick (
		.clk_i        (MCLK_I),
		.rst_n_i      (ARST_N_I),
		.pend_i       (pend),
		.level_flat_i (prio_flat),
		.thresh_i     (CPU_IPL_I),
		.found_o      (user_found),
		.vec_o        (user_vec),
		.level_o      (user_lvl)
	);

	// traps outrank users; the lowest trap number wins
	always_comb
	begin
		trap_found = 1'b0;
		trap_num   = '0;
		trap_lvl   = '0;
		for (int i = TRAP_N - 1; i >= 0; i--)
			if (trap_flags[i] && TRAP_TOP_LEVEL - 4'(i) > CPU_IPL_I)
			begin
				trap_found = 1'b1;
				trap_num   = VEC_W'(i + TRAP_LSB);
				trap_lvl   = TRAP_TOP_LEVEL - 4'(i);
			end
	end

	// ----------------------------------------------------------------
	// offer to the cpu
	// ----------------------------------------------------------------
	always_ff @(posedge MCLK_I or negedge ARST_N_I)
	begin
		if (!ARST_N_I)
		begin
			state          <= ST_IDLE;
			CPU_REQ_O      <= 1'b0;
			CPU_TRAP_O     <= 1'b0;
			CPU_VEC_NUM_O  <= '0;
			CPU_LEVEL_O    <= '0;
			CPU_VEC_ADDR_O <= RESET_ADDR;
			CPU_PC_FORCE_O <= 1'b1;
		end
		else
		begin
			CPU_PC_FORCE_O <= 1'b0;
			case (state)
				ST_IDLE :
					if (!CPU_PC_FORCE_O && (trap_found || user_found))
					begin
						state          <= ST_OFFER;
						CPU_REQ_O      <= 1'b1;
						CPU_TRAP_O     <= trap_found;
						CPU_VEC_NUM_O  <= trap_found ? trap_num : user_vec;
						CPU_LEVEL_O    <= trap_found ? trap_lvl : {1'b0, user_lvl};
						CPU_VEC_ADDR_O <= vec_addr(trap_found, trap_found ? trap_num : user_vec, alt_sel);
					end
				ST_OFFER :
					if (CPU_ACK_I)
					begin
						state     <= ST_IDLE;
						CPU_REQ_O <= 1'b0;
					end
				default :
				begin
					state     <= ST_IDLE;
					CPU_REQ_O <= 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge MCLK_I or negedge ARST_N_I)
	begin
		if (!ARST_N_I)
		begin
			status_vec  <= '0;
			status_trap <= 1'b0;
			status_lvl  <= '0;
		end
		else if (CPU_REQ_O && CPU_ACK_I)
		begin
			status_vec  <= CPU_VEC_NUM_O;
			status_trap <= CPU_TRAP_O;
			status_lvl  <= CPU_LEVEL_O;
		end
	end

	// ----------------------------------------------------------------
	// event status and interrupt line
	// ----------------------------------------------------------------
	assign ev_set = {|TRAP_I, CPU_REQ_O & CPU_ACK_I};

	always_ff @(posedge MCLK_I or negedge ARST_N_I)
	begin
		if (!ARST_N_I)
		begin
			ev_status <= '0;
			ev_en     <= '0;
			IRQ_O     <= 1'b0;
		end
		else
		begin
			// a new event outlives a clear in the same cycle
			ev_status <= (ev_status & ~(wr_evclr ? m_evclr[EV_W-1:0] : '0)) | ev_set;
			if (wr_even)
				ev_en <= m_even[EV_W-1:0];
			IRQ_O <= |(ev_status & ev_en);
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge MCLK_I); endclocking
	default disable iff (!ARST_N_I);

	sequence launch_s;
		$rose(CPU_REQ_O);
	endsequence

	sequence user_launch_s;
		launch_s ##0 !CPU_TRAP_O;
	endsequence

	user_addr_a : assert property (user_launch_s |-> CPU_VEC_ADDR_O == USER_BASE_ADDR
		+ (24'(CPU_VEC_NUM_O) << VEC_SHIFT) + ($past(alt_sel) ? ALT_OFFSET : 24'h000000))
		else $error("user vector address wrong");

	trap_addr_a : assert property (launch_s ##0 CPU_TRAP_O |-> CPU_VEC_NUM_O inside {[1:4]}
		&& CPU_VEC_ADDR_O == TRAP_BASE_ADDR + (24'(CPU_VEC_NUM_O) << VEC_SHIFT)
		+ ($past(alt_sel) ? ALT_OFFSET : 24'h000000))
		else $error("trap vector address wrong");

	reset_quiet_a : assert property (CPU_PC_FORCE_O |-> !CPU_REQ_O && CPU_VEC_ADDR_O == RESET_ADDR)
		else $error("vector offered during reset");

	user_pick_a : assert property (user_launch_s |-> CPU_VEC_NUM_O == $past(user_vec)
		&& CPU_LEVEL_O == {1'b0, $past(pick_prio)} && $past(pend[user_vec]))
		else $error("offered source does not match flags or priority");

	unimpl_zero_a : assert property ((flags & ~IMPL_MASK) == '0 && (enables & ~IMPL_MASK) == '0)
		else $error("unused vector shows a flag or enable");

	status_latch_a : assert property (CPU_REQ_O && CPU_ACK_I |=> status_vec == $past(CPU_VEC_NUM_O)
		&& status_lvl == $past(CPU_LEVEL_O))
		else $error("status latch missed taken request");

	offer_hold_a : assert property (CPU_REQ_O && !CPU_ACK_I |=> CPU_REQ_O && $stable(CPU_VEC_ADDR_O)
		&& $stable(CPU_VEC_NUM_O))
		else $error("offer changed before acknowledge");

	irq_line_a : assert property (##1 IRQ_O == $past(|(ev_status & ev_en)))
		else $error("interrupt line does not follow status");

endmodule : interrupt_vector_selector

// ==== dv/cpu_model.sv ====
// Purpose: cpu end of the vector offer link
// Assumes: an offer is held until acknowledged
// Notes:   odd vectors are answered slowly; level rises to 15 on each take
`timescale 1ns/1ps
module cpu_model (
	input  wire logic        clk_i,
	input  wire logic        rst_n_i,
	input  wire logic        req_i,
	input  wire logic [35:0] offer_i,
	input  wire logic        resume_i,
	output logic             ack_o,
	output logic      [3:0]  ipl_o,
	output logic      [35:0] seen_o,
	output int               taken_o
);
	logic [1:0] wait_cnt;
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			ack_o <= 1'b0;
			ipl_o <= 4'h0;
			wait_cnt <= 2'h0;
			seen_o <= '0;
			taken_o <= 0;
		end
		else
		begin
			ack_o <= req_i && !ack_o && (wait_cnt == (offer_i[24] ? 2'h3 : 2'h0));
			wait_cnt <= (req_i && !ack_o) ? wait_cnt + 2'h1 : 2'h0;
			// masking all levels stops the sticky flag from reoffering
			if (req_i && ack_o)
			begin
				ipl_o <= 4'hf;
				seen_o <= offer_i;
				taken_o <= taken_o + 1;
			end
			else if (resume_i)
				ipl_o <= 4'h0;
		end
	end
endmodule : cpu_model

// ==== dv/tb_top.sv ====
// Purpose: self-checking bench for the interrupt vector selector
// Assumes: bus ready inputs held high; cpu_model takes offers
// Notes:   flags are sticky, so each take is followed by a clear
`timescale 1ns/1ps
module tb_top;
	import vecsel_pkg::*;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic [7:0]  awa = 8'h00;
	logic [7:0]  ara = 8'h00;
	logic        awv = 1'b0;
	logic        wv = 1'b0;
	logic        arv = 1'b0;
	logic [31:0] wd = 32'h0;
	logic [79:0] src = '0;
	logic [3:0]  trap = 4'h0;
	logic        resume = 1'b0;
	logic        awr, wr, bv, arr, rv, req, ack, trp, pcf, irq;
	logic [1:0]  br, rr;
	logic [31:0] rd;
	logic [3:0]  ipl, lvl;
	logic [6:0]  num;
	logic [23:0] va;
	logic [35:0] seen;
	int          taken;
	int          n_fail = 0;
	int          cmp_count = 0;
	always #4 clk = ~clk;
	interrupt_vector_selector interrupt_vector_selector_i (.MCLK_I(clk), .ARST_N_I(rst_n),
		.S_AXI_AWADDR_I(awa), .S_AXI_AWVALID_I(awv), .S_AXI_AWREADY_O(awr), .S_AXI_WDATA_I(wd),
		.S_AXI_WSTRB_I(4'hf), .S_AXI_WVALID_I(wv), .S_AXI_WREADY_O(wr), .S_AXI_BRESP_O(br),
		.S_AXI_BVALID_O(bv), .S_AXI_BREADY_I(1'b1), .S_AXI_ARADDR_I(ara), .S_AXI_ARVALID_I(arv),
		.S_AXI_ARREADY_O(arr), .S_AXI_RDATA_O(rd), .S_AXI_RRESP_O(rr), .S_AXI_RVALID_O(rv),
		.S_AXI_RREADY_I(1'b1), .SRC_REQ_I(src), .TRAP_I(trap), .CPU_IPL_I(ipl), .CPU_ACK_I(ack),
		.CPU_REQ_O(req), .CPU_TRAP_O(trp), .CPU_VEC_NUM_O(num), .CPU_LEVEL_O(lvl),
		.CPU_VEC_ADDR_O(va), .CPU_PC_FORCE_O(pcf), .IRQ_O(irq));
	cpu_model cpu_model_i (.clk_i(clk), .rst_n_i(rst_n), .req_i(req), .offer_i({trp, lvl, num, va}),
		.resume_i(resume), .ack_o(ack), .ipl_o(ipl), .seen_o(seen), .taken_o(taken));
	task automatic chk(input string nm, input logic [35:0] got, input logic [35:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task automatic acc(input logic w, input logic [7:0] a, input logic [15:0] d, input logic [1:0] er);
		awa <= a;
		ara <= a;
		wd <= {16'h0, d};
		awv <= w;
		wv <= w;
		arv <= !w;
		forever
		begin
			@(posedge clk);
			if (awr) awv <= 1'b0;
			if (wr) wv <= 1'b0;
			if (arr) arv <= 1'b0;
			if (bv | rv) break;
		end
		chk("bus", w ? {bv, br, 16'h0} : {rv, rr, rd[15:0]}, {1'b1, er, w ? 16'h0 : d});
	endtask : acc
	task automatic fire(input logic [79:0] s, input logic [3:0] t, input logic [35:0] e);
		int k;
		k = taken;
		src <= s;
		trap <= t;
		@(posedge clk);
		src <= '0;
		trap <= 4'h0;
		for (int n = 0; n < 40 && taken == k; n++) @(posedge clk);
		chk("offer", seen, e);
	endtask : fire
	task automatic done;
		resume <= 1'b1;
		@(posedge clk);
		resume <= 1'b0;
	endtask : done
	function automatic logic [35:0] ev(input logic tr, input logic [3:0] l, input int n, input logic [23:0] b,
		input logic al);
		return {tr, l, 7'(n), b + 24'(2 * n) + (al ? 24'h100 : 24'h0)};
	endfunction : ev
	task automatic summarize;
		if (n_fail == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : summarize
	initial
	begin
		int vl[5] = '{0, 8, 13, 62, 77};
		int n;
		repeat (5) @(posedge clk);
		chk("reset", {pcf, req, va}, {1'b1, 1'b0, 24'h0});
		rst_n <= 1'b1;
		repeat (2) @(posedge clk);
		chk("pcforce", pcf, 1'b0);
		acc(1'b0, CTRL_OFS, 16'h0, RESP_OKAY);
		acc(1'b0, 8'hfc, 16'h0, RESP_SLVERR);
		acc(1'b1, 8'hfc, 16'h0, RESP_SLVERR);
		acc(1'b1, EVT_EN_OFS, 16'h1, RESP_OKAY);
		for (int a = 0; a < 2; a++)
		begin
			acc(1'b1, CTRL_OFS, a ? 16'h8000 : 16'h0, RESP_OKAY);
			foreach (vl[i])
			begin
				n = vl[i];
				acc(1'b1, ENAB_BASE + 8'(4 * (n / 16)), 16'h1 << (n % 16), RESP_OKAY);
				acc(1'b1, PRIO_BASE + 8'(4 * (n / 4)), 16'(i + 1) << (4 * (n % 4)), RESP_OKAY);
				fire(80'h1 << n, 4'h0, ev(1'b0, 4'(i + 1), n, 24'h14, a[0]));
				acc(1'b0, FLAG_BASE + 8'(4 * (n / 16)), 16'h1 << (n % 16), RESP_OKAY);
				acc(1'b0, STAT_OFS, 16'(((i + 1) << 8) | n), RESP_OKAY);
				chk("irq", irq, 1'b1);
				acc(1'b1, FLAG_BASE + 8'(4 * (n / 16)), 16'h0, RESP_OKAY);
				acc(1'b1, EVT_CLR_OFS, 16'h1, RESP_OKAY);
				// irq line lags the cleared status by one more edge
				@(posedge clk);
				chk("irq", irq, 1'b0);
				done();
			end
		end
		acc(1'b1, EVT_EN_OFS, 16'h0, RESP_OKAY);
		for (int t = 1; t < 5; t++)
		begin
			fire('0, 4'(1 << (t - 1)), ev(1'b1, 4'(16 - t), t, 24'h4, 1'b1));
			acc(1'b0, TRAP_OFS, 16'(1 << t), RESP_OKAY);
			chk("irq", irq, 1'b0);
			acc(1'b1, TRAP_OFS, 16'h0, RESP_OKAY);
			done();
		end
		acc(1'b1, EVT_EN_OFS, 16'h2, RESP_OKAY);
		@(posedge clk);
		chk("irq", irq, 1'b1);
		acc(1'b1, CTRL_OFS, 16'h0, RESP_OKAY);
		acc(1'b1, ENAB_BASE, 16'h2100, RESP_OKAY);
		acc(1'b1, PRIO_BASE + 8'h08, 16'h0003, RESP_OKAY);
		acc(1'b1, PRIO_BASE + 8'h0c, 16'h0030, RESP_OKAY);
		fire((80'h1 << 13) | (80'h1 << 8), 4'h0, ev(1'b0, 4'h3, 8, 24'h14, 1'b0));
		acc(1'b1, FLAG_BASE, 16'h2000, RESP_OKAY);
		done();
		fire('0, 4'h0, ev(1'b0, 4'h3, 13, 24'h14, 1'b0));
		acc(1'b1, FLAG_BASE, 16'h0, RESP_OKAY);
		acc(1'b1, ENAB_BASE + 8'h10, 16'h0, RESP_OKAY);
		done();
		acc(1'b1, FLAG_BASE + 8'h10, 16'hffff, RESP_OKAY);
		acc(1'b0, FLAG_BASE + 8'h10, IMPL_MASK[79:64], RESP_OKAY);
		summarize();
	end
	initial
	begin
		#200us;
		n_fail++;
		summarize();
	end
endmodule : tb_top
